// file: src/psq_program_sequencer_stack.sv
// Program counter, one-level return address stack and stack level indicator.
// Operation
// - 12-bit counter holds next instruction address.
// - Sequential instructions advance by instruction length.
// - Jumps load operand destination address.
// - Call saves counter, then loads target.
// - Return restores saved address into counter.
// - Reset sets counter to zero.
// - Stack level increments on call, decrements return.
// - Reset clears stack level indicator.
// - Overflow or underflow forces system reset.
// - Only call, return, reset change level.
// - Return stack is 12 bits, kept after return.
`timescale 1ns/10ps
`default_nettype none

module psq_program_sequencer_stack #(
  parameter int unsigned PC_WIDTH = psq_pkg::PC_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic instr_exec,
  input wire logic [7:0] instr_op,
  input wire logic [psq_pkg::LEN_W-1:0] instr_len,
  input wire logic [PC_WIDTH-1:0] operand_addr,
  input wire logic carry_flag,
  input wire logic status_flag,
  output logic [PC_WIDTH-1:0] program_counter,
  output logic [PC_WIDTH-1:0] return_address_stack,
  output logic stack_level_indicator,
  output logic hang_reset
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [PC_WIDTH-1:0] pc_q;
  logic [PC_WIDTH-1:0] pc_d;
  logic [PC_WIDTH-1:0] ras_q;
  logic sl_q;
  logic hang_q;
  logic is_call;
  logic is_ret;
  logic fault;
  logic [PC_WIDTH-1:0] seq_pc;

  function automatic logic jump_taken(input logic [7:0] op, input logic cy, input logic f);
    case (op)
      psq_pkg::PSQ_OP_JMP: jump_taken = 1'b1;
      psq_pkg::PSQ_OP_JC: jump_taken = cy;
      psq_pkg::PSQ_OP_JNC: jump_taken = ~cy;
      psq_pkg::PSQ_OP_JF: jump_taken = f;
      psq_pkg::PSQ_OP_JNF: jump_taken = ~f;
      default: jump_taken = 1'b0;
    endcase
  endfunction : jump_taken

  assign is_call = instr_exec && (instr_op == psq_pkg::PSQ_OP_CALL);
  assign is_ret = instr_exec && (instr_op == psq_pkg::PSQ_OP_RET);
  assign seq_pc = pc_q + PC_WIDTH'(instr_len);
  // A second call at level one or a return at level zero means the core is lost.
  // While the hang pulse stands every instruction is ignored, so no new fault is
  // raised then; otherwise a return in that cycle would stretch the pulse.
  assign fault = !hang_q && ((is_call && sl_q) || (is_ret && !sl_q));

  always_comb begin
    pc_d = pc_q;
    if (instr_exec) begin
      if (is_call) begin
        pc_d = operand_addr;
      end else if (is_ret) begin
        pc_d = ras_q;
      end else if (jump_taken(instr_op, carry_flag, status_flag)) begin
        pc_d = operand_addr;
      end else begin
        pc_d = seq_pc;
      end
    end
  end

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= PC_WIDTH'(psq_pkg::PC_RESET);
    end else if (fault || hang_q) begin
      pc_q <= PC_WIDTH'(psq_pkg::PC_RESET);
    end else begin
      pc_q <= pc_d;
    end
  end

  // ---------------------------------------------------------------
  // Stack level and hang reset
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sl_q <= psq_pkg::SL_RESET;
    end else if (fault || hang_q) begin
      sl_q <= psq_pkg::SL_RESET;
    end else if (is_call) begin
      sl_q <= 1'b1;
    end else if (is_ret) begin
      sl_q <= 1'b0;
    end
  end

  // The system reset pulse lasts one cycle; the rest of the core must honour it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hang_q <= 1'b0;
    end else begin
      hang_q <= fault;
    end
  end

  // ---------------------------------------------------------------
  // Return address stack
  // ---------------------------------------------------------------
  // Not reset: the saved address survives reset and return, as the stack RAM does.
  always_ff @(posedge core_clk) begin
    if (is_call && !sl_q && !hang_q) begin
      ras_q <= pc_q;
    end
  end

  assign program_counter = pc_q;
  assign return_address_stack = ras_q;
  assign stack_level_indicator = sl_q;
  assign hang_reset = hang_q;

endmodule : psq_program_sequencer_stack

`default_nettype wire

// file: src/psq_pkg.sv
// Package of constants and types for the program sequencer and address stack.
package psq_pkg;
  localparam int unsigned PC_W = 12;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic SL_RESET = 1'b0;
  localparam int unsigned LEN_W = 2;

  // Flow-control operation presented by instruction decode.
  typedef enum logic [7:0] {
    PSQ_OP_SEQ  = 8'h01,
    PSQ_OP_JMP  = 8'h02,
    PSQ_OP_JC   = 8'h04,
    PSQ_OP_JNC  = 8'h08,
    PSQ_OP_JF   = 8'h10,
    PSQ_OP_JNF  = 8'h20,
    PSQ_OP_CALL = 8'h40,
    PSQ_OP_RET  = 8'h80
  } psq_op_t;
endpackage : psq_pkg

// file: dv/psq_sva.sv
// Port assertions for the program sequencer.
`timescale 1ns/10ps
`default_nettype none
module psq_sva #(parameter int unsigned PC_WIDTH = 12) (
  input wire logic core_clk, rstn, instr_exec, carry_flag, status_flag,
  input wire logic [7:0] instr_op,
  input wire logic [psq_pkg::LEN_W-1:0] instr_len,
  input wire logic [PC_WIDTH-1:0] operand_addr, program_counter, return_address_stack,
  input wire logic stack_level_indicator, hang_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Instructions seen in the hang pulse cycle are ignored.
  wire go = instr_exec && !hang_reset;
  wire [7:0] op = instr_op;
  wire lvl = stack_level_indicator;
  AST_SEQ: assert property (go && op == 8'h01
    |=> program_counter == $past(program_counter + instr_len)) else $error("step");
  AST_JMP: assert property (go && op == 8'h02
    |=> program_counter == $past(operand_addr)) else $error("jump");
  AST_JCY: assert property (go && (op == 8'h04 || op == 8'h08)
    |=> program_counter == $past(carry_flag ^ op[3] ? operand_addr
    : program_counter + instr_len)) else $error("carry jump");
  AST_JFL: assert property (go && (op == 8'h10 || op == 8'h20)
    |=> program_counter == $past(status_flag ^ op[5] ? operand_addr
    : program_counter + instr_len)) else $error("status jump");
  AST_CALL: assert property (go && op == 8'h40 && !lvl
    |=> lvl && program_counter == $past(operand_addr)
    && return_address_stack == $past(program_counter)) else $error("call");
  AST_RET: assert property (go && op == 8'h80 && lvl
    |=> !lvl && program_counter == $past(return_address_stack)
    && $stable(return_address_stack)) else $error("return");
  AST_FAULT: assert property (go && (op == 8'h40 && lvl || op == 8'h80 && !lvl)
    |=> hang_reset && !lvl && program_counter == 12'h000 ##1 !hang_reset) else $error("fault");
  AST_LVL: assert property (!(instr_exec && (op == 8'h40 || op == 8'h80))
    |=> $stable(lvl)) else $error("level");
  AST_HANG: assert property (hang_reset
    |=> !lvl && program_counter == 12'h000) else $error("hang");
endmodule : psq_sva
bind psq_program_sequencer_stack psq_sva #(.PC_WIDTH(PC_WIDTH)) i_psq_sva (.*);
`default_nettype wire

// file: dv/tb_top.sv
// Testbench for the program sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 0, rstn = 0, instr_exec = 0, carry_flag = 0, status_flag = 0;
  logic [7:0] instr_op = 0;
  logic [1:0] instr_len = 0;
  logic [11:0] operand_addr = 0, program_counter, return_address_stack;
  logic stack_level_indicator, hang_reset;
  int n_fail = 0, cmp_count = 0;
  // Row: op, {hang, level, carry, status}, length, operand, next counter.
  logic [39:0] rows [20] = '{40'h01_0_3_000_003, 40'h02_0_0_ffe_ffe, 40'h01_0_3_000_001,
    40'h04_2_1_100_100, 40'h04_0_1_200_101, 40'h08_0_1_300_300, 40'h08_2_2_400_302,
    40'h10_1_1_500_500, 40'h10_0_1_600_501, 40'h20_0_1_700_700, 40'h20_1_2_800_702,
    40'h40_4_1_a00_a00, 40'h80_0_0_000_702, 40'h80_8_0_000_000, 40'h02_0_0_555_000,
    40'h40_4_0_123_123, 40'h40_8_0_456_000, 40'h00_0_1_000_000, 40'h03_0_2_000_002,
    40'h40_4_0_3c0_3c0};
  always #2.5 core_clk = ~core_clk;
  psq_program_sequencer_stack i_psq_program_sequencer_stack (.*);
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    #1000;
    n_fail++;
    stop_test();
  end
  initial begin
    logic [39:0] r;
    repeat (10) @(negedge core_clk);
    chk({hang_reset, stack_level_indicator, program_counter}, 25'h0);
    rstn = 1;
    instr_exec = 1;
    foreach (rows[i]) begin
      r = rows[i];
      instr_op = r[39:32];
      {carry_flag, status_flag, instr_len, operand_addr} = {r[29:28], r[25:24], r[23:12]};
      @(negedge core_clk);
      chk({hang_reset, stack_level_indicator, program_counter}, {r[31:30], r[11:0]});
    end
    instr_exec = 0;
    rstn = 0;
    #1;
    chk({stack_level_indicator, program_counter, return_address_stack}, 25'h002);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
